//--- src/smr_map.svh
// smr_map.svh: target address, command codes, widths and reset values
// assumes inclusion by smr_port.sv only
`ifndef SMR_MAP_SVH
`define SMR_MAP_SVH

`define SMR_TGT_ADDR      7'h30
`define SMR_ERR_W         32
`define SMR_ERR_RST       32'h0000_0000
`define SMR_RD_BYTES_LAST 2'h3
`define SMR_CMD_SHW_RD    8'h40
`define SMR_CMD_CPU_RD    8'h44
`define SMR_SHW_WR_BASE   6'h10
`define SMR_BIT_LAST      3'h7

`endif

//--- src/smr_pkg.sv
// smr_pkg.sv: types of the serial error register port
// assumes nothing of its surroundings
package smr_pkg;
  typedef enum logic [2:0] {
    s_idle,
    s_addr,
    s_cmd,
    s_data,
    s_ack,
    s_tx,
    s_txack
  } smr_state_e;
endpackage : smr_pkg

//--- src/smr_port.sv
// smr_port.sv: serial management target with shadowed error set
// assumes scl/sda arrive asynchronously from pins; sda is open-drain,
// register file answers within the mclk cycle rf_rd_out is high, on the same clock.
//
// Overview of operation
// - answer only target address 011_0000, ignore all other addresses
// - no setup registers; port works straight after reset
// - reads reach register file entries through the register file port, except indices 40h and 44h, which return the error copies
// - never forward accesses to chip links or downstream buses
// - all error registers readable, both shadow and processor copies
// - writes may only touch the shadow error set
// - shadow set carries identical error information to processor set
// - processor clear and serial clear act on their own copy only
// - single byte write only, used to clear shadow error bits
// - every read returns up to four data bytes, ending early on a master nack
`timescale 1ns/1ps
`include "smr_map.svh"

module smr_port #(
  parameter int ERR_W = `SMR_ERR_W
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_b_in,
  input  wire logic             clk_en_in,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe_out,
  input  wire logic [ERR_W-1:0] err_event_in,
  input  wire logic [ERR_W-1:0] cpu_err_clr_in,
  output logic      [ERR_W-1:0] cpu_err_out,
  output logic      [ERR_W-1:0] shadow_err_out,
  output logic                  rf_rd_out,
  output logic      [7:0]       rf_addr_out,
  input  wire logic [31:0]      rf_rdata_in
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus condition detect

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_old_reg;
  logic       sda_old_reg;

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_old_reg  <= 1'b1;
      sda_old_reg  <= 1'b1;
    end else if (clk_en_in) begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_old_reg  <= scl_sync_reg[1];
      sda_old_reg  <= sda_sync_reg[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_s     = scl_sync_reg[1];
  assign sda_s     = sda_sync_reg[1];
  assign scl_rise  = clk_en_in & scl_s & ~scl_old_reg;
  assign scl_fall  = clk_en_in & ~scl_s & scl_old_reg;
  // data edges only count as conditions while scl stays high
  assign start_det = clk_en_in & scl_s & scl_old_reg & ~sda_s & sda_old_reg;
  assign stop_det  = clk_en_in & scl_s & scl_old_reg & sda_s & ~sda_old_reg;

  ////////////////////////////////////////////////////////////////////////
  // byte engine

  smr_pkg::smr_state_e st_reg;
  smr_pkg::smr_state_e ack_nxt_reg;
  logic [2:0]          bit_reg;
  logic                byte_done_reg;
  logic [7:0]          sh_reg;
  logic [7:0]          cmd_reg;
  logic                wr_done_reg;
  logic [31:0]         rdbuf_reg;
  logic [1:0]          byte_cnt_reg;
  logic                mack_reg;
  logic                sda_drv_reg;
  logic                byte_end;
  logic                addr_hit;
  logic                cmd_is_shw;

  assign byte_end   = scl_fall & byte_done_reg;
  assign addr_hit   = (sh_reg[7:1] == `SMR_TGT_ADDR);
  assign cmd_is_shw = (cmd_reg[7:2] == `SMR_SHW_WR_BASE);

  // no setup state exists: the engine runs from the first start
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      st_reg        <= smr_pkg::s_idle;
      ack_nxt_reg   <= smr_pkg::s_idle;
      bit_reg       <= 3'h0;
      byte_done_reg <= 1'b0;
      sh_reg        <= 8'h00;
      wr_done_reg   <= 1'b0;
      byte_cnt_reg  <= 2'h0;
      mack_reg      <= 1'b0;
      sda_drv_reg   <= 1'b0;
    end else if (start_det) begin
      st_reg        <= smr_pkg::s_addr;
      bit_reg       <= 3'h0;
      byte_done_reg <= 1'b0;
      wr_done_reg   <= 1'b0;
      sda_drv_reg   <= 1'b0;
    end else if (stop_det) begin
      st_reg      <= smr_pkg::s_idle;
      sda_drv_reg <= 1'b0;
    end else begin
      case (st_reg)
        smr_pkg::s_addr, smr_pkg::s_cmd, smr_pkg::s_data: begin
          if (scl_rise) begin
            sh_reg        <= {sh_reg[6:0], sda_s};
            bit_reg       <= bit_reg + 3'h1;
            byte_done_reg <= (bit_reg == `SMR_BIT_LAST);
          end else if (byte_end) begin
            byte_done_reg <= 1'b0;
            sda_drv_reg   <= 1'b1;
            st_reg        <= smr_pkg::s_ack;
            if (st_reg == smr_pkg::s_addr) begin
              if (!addr_hit) begin
                sda_drv_reg <= 1'b0;
                st_reg      <= smr_pkg::s_idle;
              end else if (sh_reg[0]) begin
                ack_nxt_reg  <= smr_pkg::s_tx;
                byte_cnt_reg <= 2'h0;
              end else begin
                ack_nxt_reg <= smr_pkg::s_cmd;
              end
            end else if (st_reg == smr_pkg::s_cmd) begin
              ack_nxt_reg <= smr_pkg::s_data;
            end else begin
              // later bytes of a write get no ack
              wr_done_reg <= 1'b1;
              ack_nxt_reg <= smr_pkg::s_idle;
              if (wr_done_reg) begin
                sda_drv_reg <= 1'b0;
                st_reg      <= smr_pkg::s_idle;
              end
            end
          end
        end
        smr_pkg::s_ack: begin
          if (scl_fall) begin
            st_reg      <= ack_nxt_reg;
            bit_reg     <= 3'h0;
            sda_drv_reg <= (ack_nxt_reg == smr_pkg::s_tx) ? ~rdbuf_reg[31] : 1'b0;
          end
        end
        smr_pkg::s_tx: begin
          if (scl_rise) begin
            bit_reg       <= bit_reg + 3'h1;
            byte_done_reg <= (bit_reg == `SMR_BIT_LAST);
          end else if (byte_end) begin
            byte_done_reg <= 1'b0;
            sda_drv_reg   <= 1'b0;
            st_reg        <= smr_pkg::s_txack;
          end else if (scl_fall) begin
            sda_drv_reg <= ~rdbuf_reg[30];
          end
        end
        smr_pkg::s_txack: begin
          if (scl_rise) begin
            mack_reg <= ~sda_s;
          end else if (scl_fall) begin
            bit_reg <= 3'h0;
            if (mack_reg && byte_cnt_reg != `SMR_RD_BYTES_LAST) begin
              byte_cnt_reg <= byte_cnt_reg + 2'h1;
              st_reg       <= smr_pkg::s_tx;
              sda_drv_reg  <= ~rdbuf_reg[31];
            end else begin
              st_reg <= smr_pkg::s_idle;
            end
          end
        end
        default: begin
          st_reg <= smr_pkg::s_idle;
        end
      endcase
    end
  end

  // command byte survives a repeated start for the read that follows
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      cmd_reg <= 8'h00;
    end else if (clk_en_in && st_reg == smr_pkg::s_cmd && byte_end) begin
      cmd_reg <= sh_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path: register file is read-only from here, nothing leaves chip

  logic        rf_rd_reg;
  logic [31:0] rf_hold_reg;

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      rf_rd_reg   <= 1'b0;
      rf_addr_out <= 8'h00;
      rf_hold_reg <= 32'h0000_0000;
    end else if (clk_en_in) begin
      rf_rd_reg <= (st_reg == smr_pkg::s_cmd) && byte_end;
      if ((st_reg == smr_pkg::s_cmd) && byte_end) begin
        rf_addr_out <= sh_reg;
      end
      if (rf_rd_reg) begin
        rf_hold_reg <= rf_rdata_in;
      end
    end
  end

  assign rf_rd_out = rf_rd_reg;

  logic [ERR_W-1:0] cpu_err_reg;
  logic [ERR_W-1:0] shw_err_reg;

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      rdbuf_reg <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if (st_reg == smr_pkg::s_addr && byte_end && addr_hit && sh_reg[0]) begin
        if (cmd_reg == `SMR_CMD_SHW_RD) begin
          rdbuf_reg <= 32'(shw_err_reg);
        end else if (cmd_reg == `SMR_CMD_CPU_RD) begin
          rdbuf_reg <= 32'(cpu_err_reg);
        end else begin
          rdbuf_reg <= rf_hold_reg;
        end
      end else if (st_reg == smr_pkg::s_tx && scl_fall) begin
        rdbuf_reg <= {rdbuf_reg[30:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error copies: set beats clear so a coincident event is never lost

  logic [ERR_W-1:0] smb_clr;
  logic             wr_strobe;

  assign wr_strobe = (st_reg == smr_pkg::s_data) && byte_end && !wr_done_reg;

  genvar g;
  generate
    for (g = 0; g < ERR_W; g++) begin : g_clr
      assign smb_clr[g] = wr_strobe && cmd_is_shw
                          && (cmd_reg[1:0] == 2'(g / 8)) && sh_reg[g % 8];
    end
  endgenerate

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      cpu_err_reg <= ERR_W'(`SMR_ERR_RST);
    end else if (clk_en_in) begin
      cpu_err_reg <= (cpu_err_reg & ~cpu_err_clr_in) | err_event_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      shw_err_reg <= ERR_W'(`SMR_ERR_RST);
    end else if (clk_en_in) begin
      shw_err_reg <= (shw_err_reg & ~smb_clr) | err_event_in;
    end
  end

  assign cpu_err_out    = cpu_err_reg;
  assign shadow_err_out = shw_err_reg;
  assign sda_out        = 1'b0;
  assign sda_oe_out     = sda_drv_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_addr_end;
    st_reg == smr_pkg::s_addr && byte_end;
  endsequence

  sequence s_rd_addr;
    s_addr_end ##0 addr_hit && sh_reg[0];
  endsequence

  a_addr_miss: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    s_addr_end ##0 !addr_hit |=> st_reg == smr_pkg::s_idle && !sda_oe_out)
    else $error("foreign address was answered");

  a_ready_reset: assert property (@(posedge mclk_in) disable iff (1'b0)
    !rst_b_in |=> st_reg == smr_pkg::s_idle && !sda_oe_out && !rf_rd_out)
    else $error("port not idle after reset");

  a_rf_capture: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    rf_rd_out && clk_en_in |=> rf_hold_reg == $past(rf_rdata_in))
    else $error("register file data not captured");

  a_rf_local: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    $rose(rf_rd_out) |-> $past(st_reg) == smr_pkg::s_cmd && rf_addr_out == cmd_reg)
    else $error("register read without command byte");

  a_shw_read: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    s_rd_addr ##0 cmd_reg == `SMR_CMD_SHW_RD |=> rdbuf_reg == 32'($past(shw_err_reg)))
    else $error("shadow read returned wrong data");

  a_wr_only_shw: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    smb_clr != '0 |-> cmd_reg[7:2] == `SMR_SHW_WR_BASE && wr_strobe)
    else $error("write outside shadow set");

  a_same_info: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    clk_en_in && smb_clr == '0 && cpu_err_clr_in == '0 && cpu_err_reg == shw_err_reg
    |=> cpu_err_reg == shw_err_reg)
    else $error("error copies diverged");

  a_cpu_clr_indep: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    clk_en_in && smb_clr == '0 |=> (shw_err_reg & $past(shw_err_reg)) == $past(shw_err_reg))
    else $error("shadow lost bits without serial clear");

  a_one_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_strobe |=> wr_done_reg ##1 !wr_strobe)
    else $error("second write byte accepted");

  a_four_bytes: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    st_reg == smr_pkg::s_txack && scl_fall && byte_cnt_reg == `SMR_RD_BYTES_LAST
    && !start_det && !stop_det |=> st_reg == smr_pkg::s_idle)
    else $error("read ran past four bytes");

  a_err_both: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    clk_en_in && err_event_in != '0 |=>
    (cpu_err_reg & $past(err_event_in)) == $past(err_event_in)
    && (shw_err_reg & $past(err_event_in)) == $past(err_event_in))
    else $error("error not logged in both copies");

  a_other_wr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_strobe && !cmd_is_shw |-> smb_clr == '0 ##1 sda_oe_out)
    else $error("foreign write changed state");

endmodule : smr_port

//--- tb/smr_master.sv
// smr_master.sv: serial management master model, 400 ns serial clock
// assumes the bench forms the wired-AND data line with a pull-up
`timescale 1ns/1ps

module smr_master (
  input  wire logic mclk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // clock stands high between frames
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : tick

  // 4 mclk low, 4 high; read late in high so slow answers still land
  task automatic bit_xfer(input logic b, output logic seen);
    tick(2);
    sda_low_out = ~b;
    tick(2);
    scl_out = 1'b1;
    tick(4);
    seen = sda_in;
    scl_out = 1'b0;
  endtask : bit_xfer

  // also serves as repeated start from a low clock
  task automatic start_cond();
    tick(2);
    sda_low_out = 1'b0;
    tick(2);
    scl_out = 1'b1;
    tick(2);
    sda_low_out = 1'b1;
    tick(2);
    scl_out = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    tick(2);
    sda_low_out = 1'b1;
    tick(2);
    scl_out = 1'b1;
    tick(2);
    sda_low_out = 1'b0;
    tick(4);
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(last, s);
  endtask : recv_byte

  // extra adds a second data byte on purpose, to be refused
  task automatic write_txn(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                           input logic extra, output logic [3:0] ack);
    ack = 4'h0;
    start_cond();
    send_byte({a, 1'b0}, ack[0]);
    send_byte(c, ack[1]);
    send_byte(d, ack[2]);
    if (extra) send_byte(8'hff, ack[3]);
    stop_cond();
  endtask : write_txn

  task automatic read_txn(input logic [7:0] c, output logic [31:0] v, output logic [2:0] ack);
    start_cond();
    send_byte(8'h60, ack[0]);
    send_byte(c, ack[1]);
    start_cond();
    send_byte(8'h61, ack[2]);
    for (int k = 3; k >= 0; k--) recv_byte(k == 0, v[8*k +: 8]);
    stop_cond();
  endtask : read_txn
endmodule : smr_master

//--- tb/smr_port_tb.sv
// smr_port_tb.sv: self-checking bench for the serial error register port
// assumes smr_master drives the serial clock and its share of the data line
`timescale 1ns/1ps

module smr_port_tb;
  logic        mclk_in  = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [31:0] err_ev   = 32'h0;
  logic [31:0] cpu_clr  = 32'h0;
  logic [31:0] rf_rdata = 32'h0;
  logic [31:0] cpu_err, shw_err, exp_cpu, exp_shw;
  logic [7:0]  rf_addr;
  logic        scl, sda, sda_drv, sda_oe, sda_low, rf_rd;
  int          fail_count = 0;
  int          num_checks = 0;
  int          rd_pulses  = 0;

  always #25 mclk_in = ~mclk_in;
  // pull-up: line is low while either party pulls
  assign sda = ~((sda_oe & ~sda_drv) | sda_low);
  // register file model answers half a clock after the index settles, at the next falling edge
  always @(negedge mclk_in) rf_rdata <= {rf_addr, ~rf_addr, 8'h5a, 8'ha5};
  // one-cycle read strobe is seen once at the mid-cycle edge
  always @(negedge mclk_in) if (rf_rd === 1'b1) rd_pulses++;

  smr_port smr_port_i (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .clk_en_in(1'b1),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_drv), .sda_oe_out(sda_oe),
    .err_event_in(err_ev), .cpu_err_clr_in(cpu_clr), .cpu_err_out(cpu_err),
    .shadow_err_out(shw_err), .rf_rd_out(rf_rd), .rf_addr_out(rf_addr),
    .rf_rdata_in(rf_rdata));
  smr_master smr_master_i (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl),
    .sda_low_out(sda_low));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic pulse(input logic [31:0] ev, input logic [31:0] clr);
    @(negedge mclk_in);
    err_ev  = ev;
    cpu_clr = clr;
    @(negedge mclk_in);
    err_ev  = 32'h0;
    cpu_clr = 32'h0;
  endtask : pulse

  task automatic copies();
    check(cpu_err, exp_cpu);
    check(shw_err, exp_shw);
  endtask : copies

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_errors();
    check(sda_oe, 32'h0);
    check(cpu_err, 32'h0);
    check(shw_err, 32'h0);
    pulse(32'h8000_0101, 32'h0);
    exp_cpu = 32'h8000_0101;
    exp_shw = 32'h8000_0101;
    copies();
    pulse(32'h0, 32'h0000_0001);
    exp_cpu = 32'h8000_0100;
    copies();
  endtask : t_errors

  task automatic t_reads();
    logic [31:0] v;
    logic [2:0]  a;
    smr_master_i.read_txn(8'h40, v, a);
    check(v, exp_shw);
    check(a, 3'h7);
    smr_master_i.read_txn(8'h44, v, a);
    check(v, exp_cpu);
    smr_master_i.read_txn(8'h12, v, a);
    check(v, {8'h12, 8'hed, 8'h5a, 8'ha5});
    check(rf_addr, 8'h12);
    check(rd_pulses, 32'h3);
  endtask : t_reads

  task automatic t_writes();
    logic [3:0] a;
    smr_master_i.write_txn(7'h30, 8'h40, 8'h01, 1'b0, a);
    check(a, 4'h7);
    exp_shw = 32'h8000_0100;
    copies();
    smr_master_i.write_txn(7'h30, 8'h43, 8'h80, 1'b0, a);
    exp_shw = 32'h0000_0100;
    copies();
    smr_master_i.write_txn(7'h30, 8'h12, 8'hff, 1'b0, a);
    check(a, 4'h7);
    copies();
    // second data byte of ff would wipe all of lane 1 if it were taken
    pulse(32'h0000_ff00, 32'h0);
    exp_cpu = exp_cpu | 32'h0000_ff00;
    exp_shw = exp_shw | 32'h0000_ff00;
    smr_master_i.write_txn(7'h30, 8'h41, 8'h01, 1'b1, a);
    check(a, 4'h7);
    exp_shw = 32'h0000_fe00;
    copies();
  endtask : t_writes

  task automatic t_wrong_addr();
    logic [3:0] a;
    logic [6:0] addrs [2] = '{7'h31, 7'h10};
    pulse(32'hffff_ffff, 32'h0);
    exp_cpu = 32'hffff_ffff;
    exp_shw = 32'hffff_ffff;
    foreach (addrs[i]) begin
      smr_master_i.write_txn(addrs[i], 8'h40, 8'hff, 1'b0, a);
      check(a, 4'h0);
      copies();
    end
  endtask : t_wrong_addr

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge mclk_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    t_errors();
    t_reads();
    t_writes();
    t_wrong_addr();
    tally_and_finish();
  end

  // hang guard, well above the longest expected run
  initial begin
    repeat (40000) @(posedge mclk_in);
    fail_count++;
    tally_and_finish();
  end
endmodule : smr_port_tb
